// [sim/mgp_checker.sv]
// port checker for the three-group modulator top
// assumes one clock, synchronous active-high reset, bound onto mgp_top
`timescale 1ns/100ps
`default_nettype none

module mgp_checker (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic [3:0] grp_a_out,
    input wire logic [1:0] grp_b_out,
    input wire logic [1:0] grp_c_out
);
    // ****************************************
    // shadow of the control registers
    // ****************************************
    logic [7:0] ctl_r;
    logic [7:0] chn_r;
    logic [7:0] off_q1_r;
    logic [7:0] off_q2_r;
    logic [7:0] off_now;
    logic [7:0] off_all;
    logic [7:0] outs;
    assign outs = {grp_c_out, grp_b_out, grp_a_out};
    assign off_now = {{2{~ctl_r[2]}}, {2{~ctl_r[1]}}, ~chn_r[3:0] | {4{~ctl_r[0]}}};
    // off for three edges: outputs may lag a disable by two
    assign off_all = off_now & off_q1_r & off_q2_r;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ctl_r <= 8'h00;
            chn_r <= 8'h00;
        end else if (sfr_wr && sfr_addr == 8'ha2) begin
            ctl_r <= sfr_wdata;
        end else if (sfr_wr && sfr_addr == 8'ha3) begin
            chn_r <= sfr_wdata;
        end
    end
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            off_q1_r <= 8'h00;
            off_q2_r <= 8'h00;
        end else begin
            off_q1_r <= off_now;
            off_q2_r <= off_q1_r;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    reset_clear_a: assert property ($fell(sys_rst) |-> sfr_rdata == 8'h00 && outs == 8'h00)
        else $error("state not clear after reset");
    rd_hold_a: assert property (!$past(sfr_rd) |-> $stable(sfr_rdata))
        else $error("read data moved without a read");
    unmapped_zero_a: assert property ($past(sfr_rd) && $past(sfr_addr) inside {8'ha0, 8'ha8}
        |-> sfr_rdata == 8'h00) else $error("unmapped read not zero");
    wr_read_a: assert property ($past(sfr_wr, 2) && !$past(sys_rst, 2) && $past(sfr_rd)
        && !$past(sfr_wr) && $past(sfr_addr) == $past(sfr_addr, 2)
        && $past(sfr_addr) inside {[8'h99:8'h9f], [8'ha1:8'ha7], [8'ha9:8'hae]}
        |-> sfr_rdata == $past(sfr_wdata, 2)) else $error("read back differs from write");
    ctl_read_a: assert property ($past(sfr_rd) && $past(sfr_addr) == 8'ha2
        |-> sfr_rdata == $past(ctl_r)) else $error("group control read wrong");
    chan_read_a: assert property ($past(sfr_rd) && $past(sfr_addr) == 8'ha3
        |-> sfr_rdata == $past(chn_r)) else $error("channel control read wrong");
    a_off_a: assert property ((grp_a_out & off_all[3:0]) == 4'h0)
        else $error("disabled group a channel active");
    b_off_a: assert property ((grp_b_out & off_all[5:4]) == 2'h0)
        else $error("disabled group b active");
    c_off_a: assert property ((grp_c_out & off_all[7:6]) == 2'h0)
        else $error("disabled group c active");
endmodule

bind mgp_top mgp_checker u_mgp_checker (.clock(clock), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .grp_a_out(grp_a_out), .grp_b_out(grp_b_out), .grp_c_out(grp_c_out));

`default_nettype wire

// [sim/mgp_top_tb_top.sv]
// self-checking bench for the three-group modulator
// assumes mgp_top with the checker bound onto it
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, want) begin n_compared++; if ((got) !== (want)) begin n_fail++; \
    $display("FAIL %0t got %h expected %h", $time, got, want); end end

module mgp_top_tb_top;
    // ****************************************
    // stimulus, expectations and monitor
    // ****************************************
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata;
    logic [3:0] grp_a_out;
    logic [1:0] grp_b_out;
    logic [1:0] grp_c_out;
    logic [7:0] outs_v;
    logic peek = 1'b0;
    logic rd_seen = 1'b0;
    logic pk_seen = 1'b0;
    logic [7:0] e;
    logic [7:0] hit_n [8] = '{default: 8'h00};
    logic [7:0] exp_q [$];
    logic [7:0] wv [20];
    logic [15:0] dv [9];
    logic [7:0] map [20] = '{8'h99, 8'h9a, 8'h9b, 8'h9c, 8'h9d, 8'h9e, 8'h9f, 8'ha1, 8'ha2,
        8'ha3, 8'ha4, 8'ha5, 8'ha6, 8'ha7, 8'ha9, 8'haa, 8'hab, 8'hac, 8'had, 8'hae};
    int n_fail = 0;
    int n_compared = 0;
    int cyc = 0;

    always #20 clock = ~clock;

    // a concatenation cannot be bit-selected, so the outputs are gathered here
    assign outs_v = {grp_c_out, grp_b_out, grp_a_out};

    mgp_top DUT (.clock(clock), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .grp_a_out(grp_a_out), .grp_b_out(grp_b_out), .grp_c_out(grp_c_out));

    task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        sfr_wr <= w;
        sfr_rd <= r;
        sfr_addr <= a;
        sfr_wdata <= d;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] want);
        acc(1'b0, 1'b1, a, 8'h00);
        exp_q.push_back(want);
    endtask

    // high cycles of one channel while the count walks lo..hi
    function automatic logic [7:0] hits(input logic [15:0] d, input logic pol, input logic en,
        input logic [15:0] lo, input logic [15:0] hi);
        logic [7:0] n;
        n = 8'h00;
        for (int k = lo; k <= hi; k++) if (en && ((k > d) ^ pol)) n++;
        return n;
    endfunction

    task automatic trial(input logic [7:0] gc, input logic [7:0] cc);
        logic [15:0] d;
        int s;
        for (int i = 0; i < 9; i++) begin
            s = i < 4 ? 10 + 2 * i : (i < 8 ? 2 * i - 8 : 18);
            acc(1'b1, 1'b0, map[s], dv[i][7:0]);
            acc(1'b1, 1'b0, map[s + 1], dv[i][15:8]);
        end
        acc(1'b1, 1'b0, 8'ha3, cc);
        acc(1'b1, 1'b0, 8'ha2, gc);
        acc(1'b0, 1'b0, 8'h00, 8'h00);
        repeat (12) @(posedge clock);
        for (int i = 0; i < 4; i++) begin
            d = (i > 0 && gc[2 + i]) ? dv[0] : dv[i];
            exp_q.push_back(hits(d, cc[4 + i], gc[0] & cc[i], 16'h0000, dv[8]));
        end
        // group b and c window sits far from wrap, so 0 or full-scale duty is exact
        for (int i = 4; i < 8; i++) begin
            d = (i % 2 == 1 && gc[(i + 7) / 2]) ? dv[i - 1] : dv[i];
            exp_q.push_back(hits(d, 1'b0, gc[i / 2 - 1], 16'h0001, 16'h0008));
        end
        @(posedge clock);
        peek <= 1'b1;
        repeat (8) @(posedge clock);
        peek <= 1'b0;
    endtask

    task automatic wrap_up();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        if (rd_seen) begin
            e = exp_q.pop_front();
            `CHK(sfr_rdata, e)
        end
        if (pk_seen && !peek) begin
            for (int i = 0; i < 8; i++) begin
                e = exp_q.pop_front();
                `CHK(hit_n[i], e)
                hit_n[i] = 8'h00;
            end
        end
        if (peek) for (int i = 0; i < 8; i++) hit_n[i] = hit_n[i] + 8'(outs_v[i]);
        rd_seen = sfr_rd;
        pk_seen = peek;
    end

    always @(posedge clock) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            wrap_up();
        end
    end

    initial begin
        void'($urandom(32'h3eed));
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        for (int i = 0; i < 20; i++) rd(map[i], 8'h00);
        rd(8'ha0, 8'h00);
        rd(8'ha8, 8'h00);
        for (int i = 0; i < 20; i++) begin
            wv[i] = 8'($urandom);
            acc(1'b1, 1'b0, map[i], wv[i]);
        end
        // unmapped write must land nowhere
        acc(1'b1, 1'b0, 8'ha0, 8'h5a);
        for (int i = 0; i < 20; i++) rd(map[i], wv[i]);
        rd(8'ha0, 8'h00);
        acc(1'b1, 1'b0, 8'ha1, 8'h3c);
        rd(8'ha1, 8'h3c);
        for (int t = 0; t < 8; t++) begin
            for (int i = 0; i < 4; i++) dv[i] = 16'($urandom % 9);
            for (int i = 4; i < 8; i++) dv[i] = ($urandom % 2) ? 16'hffff : 16'h0000;
            dv[8] = 16'h0007;
            trial(t == 0 ? 8'h07 : (t == 1 ? 8'hff : 8'($urandom)), 8'($urandom));
        end
        wrap_up();
    end
endmodule

`default_nettype wire

// [src/mgp_channel.sv]
// one compare channel: level set by count against duty
// assumes the group counter interface and synchronous reset
`timescale 1ns/100ps
`default_nettype none

module mgp_channel (
    input wire logic clock,
    input wire logic sys_rst,
    mgp_grp_if.chan_mp grp,
    input wire logic enable,
    input wire logic polarity,
    input wire logic [15:0] duty,
    output logic level
);

    // ****************************************
    // output level
    // ****************************************
    always_ff @(posedge clock) begin
        if (sys_rst || !grp.run || !enable) begin
            level <= 1'b0;
        end else if (grp.cnt > duty) begin
            // polarity 1 drives low past the duty point
            level <= ~polarity;
        end else begin
            level <= polarity;
        end
    end

endmodule

`default_nettype wire

// [src/mgp_counter.sv]
// shared period counter of one modulator group
// assumes synchronous active-high reset on the system clock
`timescale 1ns/100ps
`default_nettype none

module mgp_counter (
    input wire logic clock,
    input wire logic sys_rst,
    mgp_grp_if.cnt_mp grp
);

    // ****************************************
    // counter, zero up to the period
    // ****************************************
    always_ff @(posedge clock) begin
        if (sys_rst || !grp.run) begin
            grp.cnt <= mgp_pkg::CNT_RESET;
            grp.wrap <= 1'b0;
        end else if (grp.cnt >= grp.period) begin
            // also catches a period lowered below the running count
            grp.cnt <= mgp_pkg::CNT_RESET;
            grp.wrap <= 1'b1;
        end else begin
            grp.cnt <= grp.cnt + 16'h0001;
            grp.wrap <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// [src/mgp_grp_if.sv]
// shared counter view of one modulator group
// assumes one system clock; driven by the counter, read by channels
`timescale 1ns/100ps
`default_nettype none

interface mgp_grp_if;
    logic run;
    logic [15:0] period;
    logic [15:0] cnt;
    logic wrap;

    modport cnt_mp (
        input run,
        input period,
        output cnt,
        output wrap
    );

    modport chan_mp (
        input run,
        input cnt,
        input wrap
    );
endinterface

`default_nettype wire

// [src/mgp_pkg.sv]
// constants for the three-group pulse-width modulator block
// assumes an 8-bit special-function-register port from the core
package mgp_pkg;

    // ****************************************
    // register addresses
    // ****************************************
    localparam logic [7:0] ADDR_B0_LOW = 8'h99;
    localparam logic [7:0] ADDR_B0_HIGH = 8'h9a;
    localparam logic [7:0] ADDR_B1_LOW = 8'h9b;
    localparam logic [7:0] ADDR_B1_HIGH = 8'h9c;
    localparam logic [7:0] ADDR_C0_LOW = 8'h9d;
    localparam logic [7:0] ADDR_C0_HIGH = 8'h9e;
    localparam logic [7:0] ADDR_C1_LOW = 8'h9f;
    localparam logic [7:0] ADDR_C1_HIGH = 8'ha1;
    localparam logic [7:0] ADDR_GROUP_CTRL = 8'ha2;
    localparam logic [7:0] ADDR_A_CHAN_CTRL = 8'ha3;
    localparam logic [7:0] ADDR_A0_LOW = 8'ha4;
    localparam logic [7:0] ADDR_A0_HIGH = 8'ha5;
    localparam logic [7:0] ADDR_A1_LOW = 8'ha6;
    localparam logic [7:0] ADDR_A1_HIGH = 8'ha7;
    localparam logic [7:0] ADDR_A2_LOW = 8'ha9;
    localparam logic [7:0] ADDR_A2_HIGH = 8'haa;
    localparam logic [7:0] ADDR_A3_LOW = 8'hab;
    localparam logic [7:0] ADDR_A3_HIGH = 8'hac;
    localparam logic [7:0] ADDR_A_PERIOD_LOW = 8'had;
    localparam logic [7:0] ADDR_A_PERIOD_HIGH = 8'hae;

    // ****************************************
    // storage slots, one byte each
    // ****************************************
    localparam int NUM_SLOTS = 20;
    localparam int SLOT_A_PERIOD = 16;
    localparam int SLOT_GROUP_CTRL = 18;
    localparam int SLOT_A_CHAN_CTRL = 19;
    localparam int NUM_CHAN = 8;
    localparam int NUM_GRP = 3;
    // low-byte slot of each channel's own duty: a0..a3, b0, b1, c0, c1
    localparam int DUTY_SLOT [NUM_CHAN] = '{8, 10, 12, 14, 0, 2, 4, 6};

    // ****************************************
    // field positions
    // ****************************************
    localparam int GRP_EN_LSB = 0;
    localparam int SRC_A1_BIT = 3;
    localparam int SRC_A2_BIT = 4;
    localparam int SRC_A3_BIT = 5;
    localparam int SRC_B1_BIT = 6;
    localparam int SRC_C1_BIT = 7;
    localparam int CHAN_EN_LSB = 0;
    localparam int CHAN_POL_LSB = 4;

    // ****************************************
    // reset values and fixed periods
    // ****************************************
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    // groups b and c have no period register: they wrap at full scale
    localparam logic [15:0] FIXED_PERIOD = 16'hffff;

    typedef logic [7:0] mgp_byte_t;
    typedef logic [15:0] mgp_word_t;

endpackage

// [src/mgp_top.sv]
// register file and group wiring of the three-group modulator
// assumes the core's sfr port: one-cycle write and read strobes
//
// Functional notes
// - group b keeps two 16-bit duties in four consecutive byte registers
// - group c keeps two 16-bit duties; channel 1 high byte sits apart
// - control bits 7..3 make a channel reuse its group channel 0 duty
// - control bits 2..0 enable groups c, b and a
// - group a polarity bits 7..4: one drives low past duty, zero high
// - group a channels 3..1 enabled by channel control bits 3..1
// - group a channel 0 enabled by channel control bit 0
// - group a keeps four 16-bit duties as low and high bytes
// - group a keeps a 16-bit period shared by its channels
`timescale 1ns/100ps
`default_nettype none

module mgp_top (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic [3:0] grp_a_out,
    output logic [1:0] grp_b_out,
    output logic [1:0] grp_c_out
);

    // ****************************************
    // address decode
    // ****************************************
    // returns {hit, slot}; shared by the write and read paths
    function automatic logic [5:0] slot_of(input logic [7:0] addr);
        logic [5:0] res;
        res = 6'h00;
        unique case (addr)
            mgp_pkg::ADDR_B0_LOW: res = 6'h20;
            mgp_pkg::ADDR_B0_HIGH: res = 6'h21;
            mgp_pkg::ADDR_B1_LOW: res = 6'h22;
            mgp_pkg::ADDR_B1_HIGH: res = 6'h23;
            mgp_pkg::ADDR_C0_LOW: res = 6'h24;
            mgp_pkg::ADDR_C0_HIGH: res = 6'h25;
            mgp_pkg::ADDR_C1_LOW: res = 6'h26;
            mgp_pkg::ADDR_C1_HIGH: res = 6'h27;
            mgp_pkg::ADDR_A0_LOW: res = 6'h28;
            mgp_pkg::ADDR_A0_HIGH: res = 6'h29;
            mgp_pkg::ADDR_A1_LOW: res = 6'h2a;
            mgp_pkg::ADDR_A1_HIGH: res = 6'h2b;
            mgp_pkg::ADDR_A2_LOW: res = 6'h2c;
            mgp_pkg::ADDR_A2_HIGH: res = 6'h2d;
            mgp_pkg::ADDR_A3_LOW: res = 6'h2e;
            mgp_pkg::ADDR_A3_HIGH: res = 6'h2f;
            mgp_pkg::ADDR_A_PERIOD_LOW: res = 6'h30;
            mgp_pkg::ADDR_A_PERIOD_HIGH: res = 6'h31;
            mgp_pkg::ADDR_GROUP_CTRL: res = 6'h32;
            mgp_pkg::ADDR_A_CHAN_CTRL: res = 6'h33;
            default: res = 6'h00;
        endcase
        return res;
    endfunction

    // ****************************************
    // register storage
    // ****************************************
    mgp_pkg::mgp_byte_t reg_r [mgp_pkg::NUM_SLOTS];
    logic [5:0] wr_slot;
    logic [5:0] rd_slot;

    assign wr_slot = slot_of(sfr_addr);
    assign rd_slot = slot_of(sfr_addr);

    // duties are used byte by byte as written; no shadow latch
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            for (int i = 0; i < mgp_pkg::NUM_SLOTS; i++) begin
                reg_r[i] <= mgp_pkg::REG_RESET;
            end
        end else if (sfr_wr && wr_slot[5]) begin
            reg_r[wr_slot[4:0]] <= sfr_wdata;
        end
    end

    // read answer one edge after the strobe, held until the next read
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sfr_rdata <= mgp_pkg::READ_UNMAPPED;
        end else if (sfr_rd) begin
            sfr_rdata <= rd_slot[5] ? reg_r[rd_slot[4:0]] : mgp_pkg::READ_UNMAPPED;
        end
    end

    // ****************************************
    // control fields
    // ****************************************
    mgp_pkg::mgp_byte_t grp_ctrl;
    mgp_pkg::mgp_byte_t chan_ctrl;
    logic [2:0] grp_en;
    logic [7:0] src_sel;
    mgp_pkg::mgp_word_t own_duty [mgp_pkg::NUM_CHAN];
    mgp_pkg::mgp_word_t eff_duty [mgp_pkg::NUM_CHAN];
    logic [7:0] chan_en;
    logic [7:0] chan_pol;
    logic [7:0] chan_lvl;

    assign grp_ctrl = reg_r[mgp_pkg::SLOT_GROUP_CTRL];
    assign chan_ctrl = reg_r[mgp_pkg::SLOT_A_CHAN_CTRL];
    assign grp_en = grp_ctrl[mgp_pkg::GRP_EN_LSB +: 3];

    genvar k;
    generate
        for (k = 0; k < mgp_pkg::NUM_CHAN; k++) begin : g_own
            assign own_duty[k] = {reg_r[mgp_pkg::DUTY_SLOT[k] + 1],
                                  reg_r[mgp_pkg::DUTY_SLOT[k]]};
        end
    endgenerate

    // channel 0 of each group always uses its own value
    always_comb begin
        src_sel = 8'h00;
        src_sel[1] = grp_ctrl[mgp_pkg::SRC_A1_BIT];
        src_sel[2] = grp_ctrl[mgp_pkg::SRC_A2_BIT];
        src_sel[3] = grp_ctrl[mgp_pkg::SRC_A3_BIT];
        src_sel[5] = grp_ctrl[mgp_pkg::SRC_B1_BIT];
        src_sel[7] = grp_ctrl[mgp_pkg::SRC_C1_BIT];
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            eff_duty[i] = src_sel[i] ? own_duty[0] : own_duty[i];
        end
        eff_duty[4] = own_duty[4];
        eff_duty[5] = src_sel[5] ? own_duty[4] : own_duty[5];
        eff_duty[6] = own_duty[6];
        eff_duty[7] = src_sel[7] ? own_duty[6] : own_duty[7];
    end

    // groups b and c have no per-channel enable or polarity of their own
    always_comb begin
        chan_en = 8'h00;
        chan_pol = 8'h00;
        chan_en[0] = chan_ctrl[mgp_pkg::CHAN_EN_LSB];
        chan_en[3:1] = chan_ctrl[mgp_pkg::CHAN_EN_LSB + 1 +: 3];
        chan_en[5:4] = 2'h3;
        chan_en[7:6] = 2'h3;
        chan_pol[3:0] = chan_ctrl[mgp_pkg::CHAN_POL_LSB +: 4];
    end

    // ****************************************
    // group counters
    // ****************************************
    mgp_grp_if grp_if [mgp_pkg::NUM_GRP] ();

    assign grp_if[0].run = grp_en[0];
    assign grp_if[1].run = grp_en[1];
    assign grp_if[2].run = grp_en[2];
    assign grp_if[0].period = {reg_r[mgp_pkg::SLOT_A_PERIOD + 1],
                               reg_r[mgp_pkg::SLOT_A_PERIOD]};
    assign grp_if[1].period = mgp_pkg::FIXED_PERIOD;
    assign grp_if[2].period = mgp_pkg::FIXED_PERIOD;

    genvar g;
    generate
        for (g = 0; g < mgp_pkg::NUM_GRP; g++) begin : g_cnt
            mgp_counter u_cnt (
                .clock(clock),
                .sys_rst(sys_rst),
                .grp(grp_if[g])
            );
        end
    endgenerate

    // ****************************************
    // channels
    // ****************************************
    genvar c;
    generate
        for (c = 0; c < 4; c++) begin : g_chan_a
            mgp_channel u_chan (
                .clock(clock),
                .sys_rst(sys_rst),
                .grp(grp_if[0]),
                .enable(chan_en[c]),
                .polarity(chan_pol[c]),
                .duty(eff_duty[c]),
                .level(chan_lvl[c])
            );
        end
        for (c = 4; c < 6; c++) begin : g_chan_b
            mgp_channel u_chan (
                .clock(clock),
                .sys_rst(sys_rst),
                .grp(grp_if[1]),
                .enable(chan_en[c]),
                .polarity(chan_pol[c]),
                .duty(eff_duty[c]),
                .level(chan_lvl[c])
            );
        end
        for (c = 6; c < 8; c++) begin : g_chan_c
            mgp_channel u_chan (
                .clock(clock),
                .sys_rst(sys_rst),
                .grp(grp_if[2]),
                .enable(chan_en[c]),
                .polarity(chan_pol[c]),
                .duty(eff_duty[c]),
                .level(chan_lvl[c])
            );
        end
    endgenerate

    // channel levels are already flops; passed straight out
    assign grp_a_out = chan_lvl[3:0];
    assign grp_b_out = chan_lvl[5:4];
    assign grp_c_out = chan_lvl[7:6];

endmodule

`default_nettype wire
